// [swt_pkg.sv]
// Constants and types shared by the supervisor watchdog timer block
package swt_pkg;

  // ****************************************
  // Timebase
  // ****************************************
  localparam int CLK_HZ     = 40_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1_000;

  // ****************************************
  // Durations in their own units
  // ****************************************
  localparam int LONG_TIMEOUT_MS  = 1600;
  localparam int SHORT_TIMEOUT_MS = 200;
  // Plain default for the capacitor-programmed timeout
  localparam int ADJ_TIMEOUT_US   = 3611;
  localparam int RST_HOLD_MS      = 200;
  localparam int EN_SETUP_US      = 150;
  localparam int CFG_INIT_US      = 381;

  // ****************************************
  // Durations in clock cycles
  // ****************************************
  localparam int LONG_TIMEOUT_CYC  = LONG_TIMEOUT_MS * CLK_PER_MS;
  localparam int SHORT_TIMEOUT_CYC = SHORT_TIMEOUT_MS * CLK_PER_MS;
  localparam int ADJ_TIMEOUT_CYC   = ADJ_TIMEOUT_US * CLK_PER_US;
  localparam int RST_HOLD_CYC      = RST_HOLD_MS * CLK_PER_MS;
  localparam int EN_SETUP_CYC      = EN_SETUP_US * CLK_PER_US;
  localparam int CFG_INIT_CYC      = CFG_INIT_US * CLK_PER_US;

  // Wide enough for the longest count (64,000,000)
  localparam int CNT_W = 27;

  // ****************************************
  // Pin synchroniser lanes
  // ****************************************
  localparam int PIN_W        = 6;
  localparam int PIN_KICK     = 0;
  localparam int PIN_EN       = 1;
  localparam int PIN_MR       = 2;
  localparam int PIN_SUPPLY   = 3;
  localparam int PIN_TSEL_HI  = 4;
  localparam int PIN_TSEL_CAP = 5;

  // ****************************************
  // State and mode encodings
  // ****************************************
  typedef enum logic [1:0] {
    SUP_ASSERT = 2'h0,
    SUP_CONFIG = 2'h1,
    SUP_HOLD   = 2'h2,
    SUP_RUN    = 2'h3
  } swt_sup_state_t;

  typedef enum logic [1:0] {
    WD_IDLE  = 2'h0,
    WD_SETUP = 2'h1,
    WD_RUN   = 2'h2,
    WD_FAULT = 2'h3
  } swt_wd_state_t;

  typedef enum logic [1:0] {
    TM_LONG  = 2'h0,
    TM_SHORT = 2'h1,
    TM_CAP   = 2'h2
  } swt_tmode_t;

  localparam swt_tmode_t TMODE_RST = TM_LONG;

endpackage

// [swt_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module swt_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

// [swt_tmr.sv]
// Saturating cycle counter with a terminal flag
`timescale 1ns/100ps
module swt_tmr (
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_n_i,
  // Control
  input  wire logic                     clr_i,
  input  wire logic [swt_pkg::CNT_W-1:0] limit_i,
  // Status
  output logic                          expired_o
);

  logic [swt_pkg::CNT_W-1:0] cnt_ff;

  // Stops at the limit so a late clear never sees a wrapped count
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (clr_i) begin
      cnt_ff <= '0;
    end else if (!expired_o) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign expired_o = (cnt_ff >= limit_i);

endmodule

// [swt_top.sv]
// Supervisor with watchdog timer: reset sequencing, pin classification, watchdog
`timescale 1ns/100ps
module swt_top #(
  parameter logic [swt_pkg::CNT_W-1:0] LONG_TIMEOUT_CYC  =
    swt_pkg::CNT_W'(swt_pkg::LONG_TIMEOUT_CYC),
  parameter logic [swt_pkg::CNT_W-1:0] SHORT_TIMEOUT_CYC =
    swt_pkg::CNT_W'(swt_pkg::SHORT_TIMEOUT_CYC),
  parameter logic [swt_pkg::CNT_W-1:0] ADJ_TIMEOUT_CYC   =
    swt_pkg::CNT_W'(swt_pkg::ADJ_TIMEOUT_CYC),
  parameter logic [swt_pkg::CNT_W-1:0] RST_HOLD_CYC      =
    swt_pkg::CNT_W'(swt_pkg::RST_HOLD_CYC),
  parameter logic [swt_pkg::CNT_W-1:0] EN_SETUP_CYC      =
    swt_pkg::CNT_W'(swt_pkg::EN_SETUP_CYC),
  parameter logic [swt_pkg::CNT_W-1:0] CFG_INIT_CYC      =
    swt_pkg::CNT_W'(swt_pkg::CFG_INIT_CYC)
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Supply monitor and manual reset pins
  input  wire logic supply_valid_i,
  input  wire logic manual_rst_n_i,
  // Watchdog pins
  input  wire logic watchdog_kick_in_i,
  input  wire logic watchdog_enable_sel_i,
  // Timeout select pin sense levels
  input  wire logic timeout_select_pin_hi_i,
  input  wire logic timeout_select_pin_cap_i,
  // Supervisor reset, open drain
  output logic      supervisor_rst_n_o,
  output logic      supervisor_rst_oe_o,
  // Watchdog fault, open drain
  output logic      watchdog_fault_n_o,
  output logic      watchdog_fault_oe_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [swt_pkg::PIN_W-1:0] pin_raw;
  logic [swt_pkg::PIN_W-1:0] pin_s;

  assign pin_raw[swt_pkg::PIN_KICK]     = watchdog_kick_in_i;
  assign pin_raw[swt_pkg::PIN_EN]       = watchdog_enable_sel_i;
  assign pin_raw[swt_pkg::PIN_MR]       = manual_rst_n_i;
  assign pin_raw[swt_pkg::PIN_SUPPLY]   = supply_valid_i;
  assign pin_raw[swt_pkg::PIN_TSEL_HI]  = timeout_select_pin_hi_i;
  assign pin_raw[swt_pkg::PIN_TSEL_CAP] = timeout_select_pin_cap_i;

  swt_sync #(
    .W (swt_pkg::PIN_W)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .d_i       (pin_raw),
    .q_o       (pin_s)
  );

  logic kick_s;
  logic en_s;
  logic mr_n_s;
  logic supply_s;
  logic sup_ok;

  assign kick_s   = pin_s[swt_pkg::PIN_KICK];
  assign en_s     = pin_s[swt_pkg::PIN_EN];
  assign mr_n_s   = pin_s[swt_pkg::PIN_MR];
  assign supply_s = pin_s[swt_pkg::PIN_SUPPLY];
  assign sup_ok   = supply_s & mr_n_s;

  // ****************************************
  // Edge detection
  // ****************************************
  logic kick_dly_ff;
  logic en_dly_ff;
  logic kick_fall;
  logic en_rise;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      kick_dly_ff <= 1'b0;
      en_dly_ff   <= 1'b0;
    end else begin
      kick_dly_ff <= kick_s;
      en_dly_ff   <= en_s;
    end
  end

  assign kick_fall = kick_dly_ff & ~kick_s;
  assign en_rise   = ~en_dly_ff & en_s;

  // ****************************************
  // Supervisor sequencer
  // ****************************************
  swt_pkg::swt_sup_state_t sup_state_ff;
  swt_pkg::swt_sup_state_t nxt_sup_state;
  logic                    cfg_done_ff;
  logic                    sup_expired;
  logic                    sup_clr;
  logic [swt_pkg::CNT_W-1:0] sup_limit;

  always_comb begin
    nxt_sup_state = sup_state_ff;
    case (sup_state_ff)
      swt_pkg::SUP_ASSERT: begin
        if (supply_s && !cfg_done_ff) begin
          nxt_sup_state = swt_pkg::SUP_CONFIG;
        end else if (sup_ok) begin
          nxt_sup_state = swt_pkg::SUP_HOLD;
        end
      end
      swt_pkg::SUP_CONFIG: begin
        if (!supply_s) begin
          nxt_sup_state = swt_pkg::SUP_ASSERT;
        end else if (sup_expired) begin
          nxt_sup_state = mr_n_s ? swt_pkg::SUP_HOLD : swt_pkg::SUP_ASSERT;
        end
      end
      swt_pkg::SUP_HOLD: begin
        if (!sup_ok) begin
          nxt_sup_state = swt_pkg::SUP_ASSERT;
        end else if (sup_expired) begin
          nxt_sup_state = swt_pkg::SUP_RUN;
        end
      end
      swt_pkg::SUP_RUN: begin
        if (!sup_ok) begin
          nxt_sup_state = swt_pkg::SUP_ASSERT;
        end
      end
      default: begin
        nxt_sup_state = swt_pkg::SUP_ASSERT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sup_state_ff <= swt_pkg::SUP_ASSERT;
    end else begin
      sup_state_ff <= nxt_sup_state;
    end
  end

  // Classification is repeated only after the supply has dropped out
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done_ff <= 1'b0;
    end else if (!supply_s) begin
      cfg_done_ff <= 1'b0;
    end else if (sup_state_ff == swt_pkg::SUP_CONFIG && sup_expired) begin
      cfg_done_ff <= 1'b1;
    end
  end

  assign sup_clr   = (nxt_sup_state != sup_state_ff) ||
                     (sup_state_ff == swt_pkg::SUP_ASSERT);
  assign sup_limit = (sup_state_ff == swt_pkg::SUP_CONFIG) ?
                     CFG_INIT_CYC : RST_HOLD_CYC;

  swt_tmr u_sup_tmr (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .clr_i     (sup_clr),
    .limit_i   (sup_limit),
    .expired_o (sup_expired)
  );

  // ****************************************
  // Timeout select classification
  // ****************************************
  swt_pkg::swt_tmode_t tmode_ff;

  // Capacitor sense takes priority: a charging pin also reads high late
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tmode_ff <= swt_pkg::TMODE_RST;
    end else if (sup_state_ff == swt_pkg::SUP_CONFIG && sup_expired) begin
      if (pin_s[swt_pkg::PIN_TSEL_CAP]) begin
        tmode_ff <= swt_pkg::TM_CAP;
      end else if (pin_s[swt_pkg::PIN_TSEL_HI]) begin
        tmode_ff <= swt_pkg::TM_SHORT;
      end else begin
        tmode_ff <= swt_pkg::TM_LONG;
      end
    end
  end

  logic [swt_pkg::CNT_W-1:0] timeout_limit;

  always_comb begin
    case (tmode_ff)
      swt_pkg::TM_SHORT: timeout_limit = SHORT_TIMEOUT_CYC;
      swt_pkg::TM_CAP:   timeout_limit = ADJ_TIMEOUT_CYC;
      default:           timeout_limit = LONG_TIMEOUT_CYC;
    endcase
  end

  // ****************************************
  // Watchdog sequencer
  // ****************************************
  swt_pkg::swt_wd_state_t wd_state_ff;
  swt_pkg::swt_wd_state_t nxt_wd_state;
  logic                   wd_allowed;
  logic                   en_pend_ff;
  logic                   wd_expired;
  logic                   wd_clr;
  logic [swt_pkg::CNT_W-1:0] wd_limit;

  assign wd_allowed = (sup_state_ff == swt_pkg::SUP_RUN) && en_dly_ff;

  // Set wins; dropped outside RUN since synced pins read low after reset
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_pend_ff <= 1'b0;
    end else if (en_rise) begin
      en_pend_ff <= 1'b1;
    end else if (wd_state_ff == swt_pkg::WD_SETUP || sup_state_ff != swt_pkg::SUP_RUN) begin
      en_pend_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_wd_state = wd_state_ff;
    case (wd_state_ff)
      swt_pkg::WD_IDLE: begin
        if (wd_allowed) begin
          nxt_wd_state = en_pend_ff ? swt_pkg::WD_SETUP : swt_pkg::WD_RUN;
        end
      end
      swt_pkg::WD_SETUP: begin
        if (!wd_allowed) begin
          nxt_wd_state = swt_pkg::WD_IDLE;
        end else if (wd_expired) begin
          nxt_wd_state = swt_pkg::WD_RUN;
        end
      end
      swt_pkg::WD_RUN: begin
        if (!wd_allowed) begin
          nxt_wd_state = swt_pkg::WD_IDLE;
        end else if (wd_expired) begin
          nxt_wd_state = swt_pkg::WD_FAULT;
        end
      end
      swt_pkg::WD_FAULT: begin
        if (!wd_allowed) begin
          nxt_wd_state = swt_pkg::WD_IDLE;
        end else if (wd_expired) begin
          nxt_wd_state = swt_pkg::WD_RUN;
        end
      end
      default: begin
        nxt_wd_state = swt_pkg::WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wd_state_ff <= swt_pkg::WD_IDLE;
    end else begin
      wd_state_ff <= nxt_wd_state;
    end
  end

  // Kicks only restart the count while timing; elsewhere they are ignored
  assign wd_clr = (nxt_wd_state != wd_state_ff) ||
                  (wd_state_ff == swt_pkg::WD_IDLE) ||
                  (wd_state_ff == swt_pkg::WD_RUN && kick_fall);

  always_comb begin
    case (wd_state_ff)
      swt_pkg::WD_SETUP: wd_limit = EN_SETUP_CYC;
      swt_pkg::WD_FAULT: wd_limit = RST_HOLD_CYC;
      default:           wd_limit = timeout_limit;
    endcase
  end

  swt_tmr u_wd_tmr (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .clr_i     (wd_clr),
    .limit_i   (wd_limit),
    .expired_o (wd_expired)
  );

  // ****************************************
  // Open-drain outputs
  // ****************************************
  logic sup_rst_oe_ff;
  logic wd_fault_oe_ff;

  // Separate flops keep the two pins independent of each other
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sup_rst_oe_ff <= 1'b1;
    end else begin
      sup_rst_oe_ff <= (nxt_sup_state != swt_pkg::SUP_RUN);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wd_fault_oe_ff <= 1'b0;
    end else begin
      wd_fault_oe_ff <= (nxt_wd_state == swt_pkg::WD_FAULT);
    end
  end

  assign supervisor_rst_n_o  = 1'b0;
  assign supervisor_rst_oe_o = sup_rst_oe_ff;
  assign watchdog_fault_n_o  = 1'b0;
  assign watchdog_fault_oe_o = wd_fault_oe_ff;

endmodule

// [swt_monitor.sv]
// Port-level assertion checker for the supervisor watchdog timer
`timescale 1ns/100ps
module swt_monitor #(
  parameter int LONG_C  = 400,
  parameter int SHORT_C = 100,
  parameter int ADJ_C   = 60,
  parameter int HOLD_C  = 50,
  parameter int SETUP_C = 20
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pins in
  input wire logic supply_valid_i,
  input wire logic manual_rst_n_i,
  input wire logic watchdog_kick_in_i,
  input wire logic watchdog_enable_sel_i,
  input wire logic timeout_select_pin_hi_i,
  input wire logic timeout_select_pin_cap_i,
  // Pins out
  input wire logic supervisor_rst_n_o,
  input wire logic supervisor_rst_oe_o,
  input wire logic watchdog_fault_n_o,
  input wire logic watchdog_fault_oe_o
);
  // ****
  // Helper counters
  // ****
  int   lim;
  int   idle_ff;
  int   en_age_ff;
  int   flt_ff;
  int   sup_ff;
  logic kick_d_ff;
  logic armed;
  logic kick_fall;
  assign lim = timeout_select_pin_cap_i ? ADJ_C : (timeout_select_pin_hi_i ? SHORT_C : LONG_C);
  assign armed = watchdog_enable_sel_i && !supervisor_rst_oe_o && !watchdog_fault_oe_o;
  assign kick_fall = kick_d_ff && !watchdog_kick_in_i;
  // Kicks near the end of setup are ambiguous, so they are not credited
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kick_d_ff <= 1'b0;
      en_age_ff <= 0;
      idle_ff   <= 0;
      flt_ff    <= 0;
      sup_ff    <= 0;
    end else begin
      kick_d_ff <= watchdog_kick_in_i;
      en_age_ff <= !watchdog_enable_sel_i ? 0 : (en_age_ff < SETUP_C + 4 ? en_age_ff + 1 : en_age_ff);
      idle_ff   <= (!armed || en_age_ff < SETUP_C) ? 0 :
                   ((kick_fall && en_age_ff >= SETUP_C + 4) ? 0 : idle_ff + 1);
      flt_ff    <= watchdog_fault_oe_o ? flt_ff + 1 : 0;
      sup_ff    <= supervisor_rst_oe_o ? sup_ff + 1 : 0;
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_fault_start;
    $rose(watchdog_fault_oe_o);
  endsequence
  sequence s_fault_end;
    $fell(watchdog_fault_oe_o) && watchdog_enable_sel_i && manual_rst_n_i && supply_valid_i;
  endsequence
  a_fault_not_early: assert property (s_fault_start |-> idle_ff >= lim)
    else $error("fault raised before timeout");
  a_fault_due_bound: assert property (idle_ff <= lim + 10)
    else $error("fault missing after timeout");
  a_fault_hold_len: assert property (s_fault_end |-> flt_ff >= HOLD_C && flt_ff <= HOLD_C + 1)
    else $error("fault pulse length wrong");
  a_fault_off_rst: assert property (supervisor_rst_oe_o [*3] |-> !watchdog_fault_oe_o)
    else $error("fault driven during reset");
  a_fault_off_dis: assert property ((!watchdog_enable_sel_i) [*6] |-> !watchdog_fault_oe_o)
    else $error("fault driven while disabled");
  a_rst_hold_len: assert property ($fell(supervisor_rst_oe_o) |-> sup_ff >= HOLD_C)
    else $error("reset released too early");
  a_rst_on_drop: assert property (($fell(supply_valid_i) || $fell(manual_rst_n_i))
    |-> ##[1:8] supervisor_rst_oe_o)
    else $error("reset not asserted on drop");
  a_fault_indep: assert property (s_fault_start and (supply_valid_i && manual_rst_n_i)
    |-> !supervisor_rst_oe_o)
    else $error("fault came with system reset");
  a_od_data_low: assert property (!supervisor_rst_n_o && !watchdog_fault_n_o)
    else $error("open drain data not low");
endmodule

// [swt_host_model.sv]
// Host model that services the watchdog kick pin
`timescale 1ns/100ps
module swt_host_model (
  // Clock
  input  wire logic        sys_clk_i,
  // Control
  input  wire logic        run_i,
  input  wire logic        idle_lvl_i,
  input  wire logic [15:0] period_i,
  // Kick pin
  output logic             kick_o
);
  logic [15:0] cnt_ff  = 16'h0000;
  logic        kick_ff = 1'b1;
  assign kick_o = kick_ff;
  // One falling edge per period, kept well inside the timeout
  always @(posedge sys_clk_i) begin
    if (!run_i) begin
      cnt_ff  <= 16'h0000;
      kick_ff <= idle_lvl_i;
    end else begin
      cnt_ff  <= (cnt_ff + 16'h0001 >= period_i) ? 16'h0000 : cnt_ff + 16'h0001;
      kick_ff <= (cnt_ff < (period_i >> 1));
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the supervisor watchdog timer
`timescale 1ns/100ps
module tb_top;
  // ****
  // Shortened counts
  // ****
  localparam int LONG_C  = 400;
  localparam int SHORT_C = 100;
  localparam int ADJ_C   = 60;
  localparam int HOLD_C  = 50;
  localparam int SETUP_C = 20;
  localparam int CFG_C   = 30;
  localparam int W       = swt_pkg::CNT_W;
  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic        supply      = 1'b0;
  logic        mr_n        = 1'b1;
  logic        en          = 1'b1;
  logic        tsel_hi     = 1'b0;
  logic        tsel_cap    = 1'b0;
  logic        run         = 1'b0;
  logic        lvl         = 1'b0;
  logic [15:0] per         = 16'h0014;
  wire         kick;
  wire         sup_n;
  wire         sup_oe;
  wire         flt_n;
  wire         flt_oe;
  int          err_total   = 0;
  int          comparisons = 0;
  int          m;
  always #12.5 clk = ~clk;
  swt_top #(
    .LONG_TIMEOUT_CYC(W'(LONG_C)), .SHORT_TIMEOUT_CYC(W'(SHORT_C)), .ADJ_TIMEOUT_CYC(W'(ADJ_C)),
    .RST_HOLD_CYC(W'(HOLD_C)), .EN_SETUP_CYC(W'(SETUP_C)), .CFG_INIT_CYC(W'(CFG_C))
  ) swt_top_i (
    .sys_clk_i(clk), .rst_n_i(rst_n), .supply_valid_i(supply), .manual_rst_n_i(mr_n),
    .watchdog_kick_in_i(kick), .watchdog_enable_sel_i(en),
    .timeout_select_pin_hi_i(tsel_hi), .timeout_select_pin_cap_i(tsel_cap),
    .supervisor_rst_n_o(sup_n), .supervisor_rst_oe_o(sup_oe),
    .watchdog_fault_n_o(flt_n), .watchdog_fault_oe_o(flt_oe)
  );
  swt_host_model swt_host_model_i (
    .sys_clk_i(clk), .run_i(run), .idle_lvl_i(lvl), .period_i(per), .kick_o(kick)
  );
  // ****
  // Helpers
  // ****
  task automatic check_rng(input string nm, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic check_bit(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // Cycles until an output reaches a level, capped against a hang
  task automatic wait_lvl(input bit flt, input logic val, input int cap, output int k);
    k = 0;
    while (k < cap && (flt ? flt_oe : sup_oe) !== val) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic count_hi(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (flt_oe !== 1'b0) k++;
    end
  endtask
  task automatic power(input logic hi, input logic cap);
    @(posedge clk);
    supply   <= 1'b0;
    tsel_hi  <= hi;
    tsel_cap <= cap;
    lvl      <= 1'b0;
    repeat (8) @(negedge clk);
    check_bit("rst_oe low supply", 1'b1, sup_oe);
    check_bit("fault_oe low supply", 1'b0, flt_oe);
    check_bit("od data low", 1'b0, sup_n | flt_n);
    @(posedge clk);
    supply <= 1'b1;
    wait_lvl(1'b0, 1'b0, 500, m);
    check_rng("reset release", CFG_C + HOLD_C, CFG_C + HOLD_C + 8, m);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_modes;
    int lim;
    for (int i = 0; i < 3; i++) begin
      lim = (i == 0) ? LONG_C : ((i == 1) ? SHORT_C : ADJ_C);
      power(i == 1, i == 2);
      repeat (lim / 2) @(posedge clk);
      lvl <= 1'b1;
      wait_lvl(1'b1, 1'b1, lim, m);
      check_rng("timeout", lim, lim + 6, lim / 2 + m);
      check_bit("rst_oe in fault", 1'b0, sup_oe);
      wait_lvl(1'b1, 1'b0, 2 * HOLD_C, m);
      check_rng("fault hold", HOLD_C, HOLD_C + 1, m);
      wait_lvl(1'b1, 1'b1, 2 * lim, m);
      check_rng("restart", lim, lim + 4, m);
    end
  endtask
  task automatic t_service;
    wait_lvl(1'b1, 1'b0, 2 * HOLD_C, m);
    @(posedge clk);
    run <= 1'b1;
    count_hi(6 * ADJ_C, m);
    check_rng("fault serviced", 0, 0, m);
    @(posedge clk);
    run <= 1'b0;
    wait_lvl(1'b1, 1'b1, 2 * ADJ_C, m);
    check_rng("last kick timeout", ADJ_C - 20, ADJ_C + 6, m);
  endtask
  task automatic t_enable;
    @(posedge clk);
    en  <= 1'b0;
    lvl <= 1'b1;
    repeat (8) @(negedge clk);
    check_bit("fault_oe disabled", 1'b0, flt_oe);
    count_hi(3 * ADJ_C, m);
    check_rng("fault disabled", 0, 0, m);
    @(posedge clk);
    en <= 1'b1;
    repeat (5) @(posedge clk);
    lvl <= 1'b0;
    wait_lvl(1'b1, 1'b1, 3 * ADJ_C, m);
    check_rng("enable timeout", SETUP_C + ADJ_C - 2, SETUP_C + ADJ_C + 10, m + 5);
  endtask
  task automatic t_reset;
    @(posedge clk);
    mr_n <= 1'b0;
    run  <= 1'b1;
    repeat (8) @(negedge clk);
    check_bit("rst_oe manual", 1'b1, sup_oe);
    check_bit("fault_oe manual", 1'b0, flt_oe);
    repeat (40) @(posedge clk);
    run  <= 1'b0;
    mr_n <= 1'b1;
    wait_lvl(1'b1, 1'b1, 3 * (HOLD_C + ADJ_C), m);
    check_rng("resume timeout", HOLD_C + ADJ_C, HOLD_C + ADJ_C + 12, m);
  endtask
  task automatic final_report;
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_modes();
    t_service();
    t_enable();
    t_reset();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule

bind swt_top swt_monitor #(
  .LONG_C(LONG_TIMEOUT_CYC), .SHORT_C(SHORT_TIMEOUT_CYC), .ADJ_C(ADJ_TIMEOUT_CYC),
  .HOLD_C(RST_HOLD_CYC), .SETUP_C(EN_SETUP_CYC)
) swt_monitor_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_valid_i(supply_valid_i),
  .manual_rst_n_i(manual_rst_n_i), .watchdog_kick_in_i(watchdog_kick_in_i),
  .watchdog_enable_sel_i(watchdog_enable_sel_i),
  .timeout_select_pin_hi_i(timeout_select_pin_hi_i),
  .timeout_select_pin_cap_i(timeout_select_pin_cap_i),
  .supervisor_rst_n_o(supervisor_rst_n_o), .supervisor_rst_oe_o(supervisor_rst_oe_o),
  .watchdog_fault_n_o(watchdog_fault_n_o), .watchdog_fault_oe_o(watchdog_fault_oe_o)
);
